// [inc/pia_pkg.sv]
// shared constants and helper functions of the priority interrupt acceptance block
package pia_pkg;

   // ------------------------------------------------------------------
   // source layout
   // ------------------------------------------------------------------
   localparam int NUM_PINS   = 8;
   localparam int NUM_PERIPH = 8;
   localparam int NUM_SRC    = NUM_PINS + NUM_PERIPH;
   localparam int LVL_W      = 4;
   localparam int SRC_W      = 4;
   localparam int NUM_DMA_CH = 4;
   localparam int ADDR_W     = 8;

   // ------------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_PRIO_LO  = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PRIO_HI  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_SENSE    = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_FLAGS    = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_DMA_CTRL = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_DMA_SEL  = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_XFER_EN  = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_XFER_SEL = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h20;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int DMA_CTRL_DME_BIT = 0;
   localparam int DMA_CTRL_DE_LSB  = 1;
   localparam int STAT_IRQ_BIT     = 0;
   localparam int STAT_LVL_LSB     = 4;
   localparam int STAT_SRC_LSB     = 8;
   localparam int STAT_REQ_LSB     = 16;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [NUM_SRC*LVL_W-1:0]    RST_PRIO  = 64'h0;
   localparam logic [NUM_PINS-1:0]         RST_SENSE = 8'h00;
   localparam logic [NUM_SRC-1:0]          RST_XFER  = 16'h0000;
   localparam logic [NUM_DMA_CH*SRC_W-1:0] RST_DSEL  = 16'h0000;
   localparam logic [31:0]                 RST_WORD  = 32'h0000_0000;

   // level of one source out of the packed priority fields
   function automatic logic [LVL_W-1:0] pia_level(
      input logic [NUM_SRC*LVL_W-1:0] prio,
      input int                       src);
      pia_level = prio[src*LVL_W +: LVL_W];
   endfunction

   // sources claimed by an enabled dma channel while the master enable is set
   function automatic logic [NUM_SRC-1:0] pia_dma_claim(
      input logic                         dma_master_enable,
      input logic [NUM_DMA_CH-1:0]        de,
      input logic [NUM_DMA_CH*SRC_W-1:0]  dsel,
      input logic [NUM_DMA_CH-1:0]        chmask);
      pia_dma_claim = '0;
      for (int c = 0; c < NUM_DMA_CH; c++) begin
         if (dma_master_enable && de[c] && chmask[c]) begin
            pia_dma_claim[dsel[c*SRC_W +: SRC_W]] = 1'b1;
         end
      end
   endfunction

endpackage

// [hdl/pia_pin_front.sv]
// pin front end: two-stage synchroniser, low level and falling edge detection
`timescale 1ns/1ps
module pia_pin_front #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   input  wire logic [WIDTH-1:0] pin_n_i,
   output logic      [WIDTH-1:0] level_low_o,
   output logic      [WIDTH-1:0] fall_o
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
      logic [WIDTH-1:0] prev;
      logic [WIDTH-1:0] low;
      logic [WIDTH-1:0] fall;
   } pia_front_s;

   pia_front_s st_r;
   pia_front_s st_nxt;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.meta = pin_n_i;
      st_nxt.sync = st_r.meta;
      st_nxt.prev = st_r.sync;
      st_nxt.low  = ~st_r.sync;
      // only the second stage and its delayed copy are looked at, never the first
      st_nxt.fall = st_r.prev & ~st_r.sync;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         // pins idle high, so no false edge after reset
         st_r <= '{meta: '1, sync: '1, prev: '1, low: '0, fall: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level_low_o = st_r.low;
   assign fall_o      = st_r.fall;

endmodule

// [hdl/pia_top.sv]
// priority interrupt acceptance: arbitration, mask compare, request pin and apb registers
//
// What this block does
// - the highest programmed level among all live requests wins each round
// - a losing edge request stays pending; pin flags may be withdrawn by software
// - power-on and manual reset both clear every pending edge request
// - equal levels are resolved by the fixed source order, lowest index first
// - winner goes to the cpu only when its level is strictly above the mask
// - accepting drives the active-low request pin low, same as cpu request
// - level and peripheral requests release the pin once the mask is raised
// - edge requests release the pin when the cpu starts exception processing
// - a higher request accepted meanwhile keeps the pin low
// - transfer-activation judgment takes one state, peripherals none extra
// - identify and compare take three states for peripherals, four for pins
// - sources claimed by an enabled dma channel are hidden from the cpu path
// - a set activation enable suppresses the cpu interrupt of that source
// - activation enable clears at transfer end when irq-select or count zero
// - source flag clears at qualified transfer end or at dma transfer end
// - each source has a 4-bit level, 0 lowest and 15 highest
// - pin sense bit 0 senses low level, 1 senses falling edge
// - in edge mode writing zero after reading one withdraws the pin flag
`timescale 1ns/1ps
module pia_top
   import pia_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  reset_i,
   input  wire logic                  manual_reset_i,
   // apb slave
   input  wire logic                  psel_i,
   input  wire logic                  penable_i,
   input  wire logic                  pwrite_i,
   input  wire logic [ADDR_W-1:0]     paddr_i,
   input  wire logic [31:0]           pwdata_i,
   output logic      [31:0]           prdata_o,
   output logic                       pready_o,
   output logic                       pslverr_o,
   // request sources
   input  wire logic [NUM_PINS-1:0]   pin_req_n_i,
   input  wire logic [NUM_PERIPH-1:0] periph_req_i,
   output logic      [NUM_PERIPH-1:0] periph_flag_clr_o,
   // cpu side
   input  wire logic [LVL_W-1:0]      cpu_mask_level_i,
   input  wire logic                  cpu_exc_start_i,
   output logic                       cpu_irq_o,
   output logic      [LVL_W-1:0]      cpu_irq_level_o,
   output logic      [SRC_W-1:0]      cpu_irq_src_o,
   output logic                       interrupt_out_n_o,
   // dma and data transfer controllers
   output logic      [NUM_SRC-1:0]    dma_trigger_o,
   input  wire logic [NUM_DMA_CH-1:0] dma_done_i,
   output logic      [NUM_SRC-1:0]    xfer_trigger_o,
   input  wire logic                  xfer_done_i,
   input  wire logic [SRC_W-1:0]      xfer_src_i,
   input  wire logic                  xfer_count_zero_i
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [NUM_SRC*LVL_W-1:0]    prio;
      logic [NUM_PINS-1:0]         sense;
      logic [NUM_PINS-1:0]         edge_flag;
      logic [NUM_PINS-1:0]         seen_one;
      logic [NUM_PINS-1:0]         pin_stage;
      logic                        dma_master_enable;
      logic [NUM_DMA_CH-1:0]       de;
      logic [NUM_DMA_CH*SRC_W-1:0] dsel;
      logic [NUM_SRC-1:0]          xen;
      logic [NUM_SRC-1:0]          xsel;
      logic [NUM_SRC-1:0]          req;
      logic                        win_vld;
      logic [SRC_W-1:0]            win_src;
      logic [LVL_W-1:0]            win_lvl;
      logic                        irq;
      logic                        irq_n;
      logic [LVL_W-1:0]            acc_lvl;
      logic [SRC_W-1:0]            acc_src;
      logic [NUM_SRC-1:0]          dma_trig;
      logic [NUM_SRC-1:0]          xfer_trig;
      logic [NUM_PERIPH-1:0]       periph_clr;
      logic                        pready;
      logic                        pslverr;
      logic [31:0]                 prdata;
   } pia_state_s;

   pia_state_s st_r;
   pia_state_s st_nxt;

   logic [NUM_PINS-1:0] pin_low;
   logic [NUM_PINS-1:0] pin_fall;

   // ------------------------------------------------------------------
   // pin front end
   // ------------------------------------------------------------------
   pia_pin_front #(
      .WIDTH       (NUM_PINS)
   ) u_front (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .pin_n_i     (pin_req_n_i),
      .level_low_o (pin_low),
      .fall_o      (pin_fall)
   );

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      logic [NUM_PINS-1:0]  pin_flags;
      logic [NUM_SRC-1:0]   src_vec;
      logic [NUM_SRC-1:0]   dma_hide;
      logic [NUM_SRC-1:0]   flag_clr;
      logic [NUM_SRC-1:0]   kill;
      logic                 acc_is_edge;
      logic                 wr;
      logic                 rd;
      logic                 found;
      logic [SRC_W-1:0]     best_src;
      logic [LVL_W-1:0]     best_lvl;
      logic [31:0]          rdata;
      logic                 bad;
      st_nxt      = st_r;
      pin_flags   = '0;
      src_vec     = '0;
      dma_hide    = '0;
      flag_clr    = '0;
      kill        = '0;
      acc_is_edge = 1'b0;
      wr          = 1'b0;
      rd          = 1'b0;
      found       = 1'b0;
      best_src    = '0;
      best_lvl    = '0;
      rdata       = RST_WORD;
      bad         = 1'b0;

      // pin flag: edge latch or live low level
      for (int i = 0; i < NUM_PINS; i++) begin
         pin_flags[i] = st_r.sense[i] ? st_r.edge_flag[i] : pin_low[i];
      end

      // sources as seen after the pin judgment state
      src_vec = {periph_req_i, st_r.pin_stage};

      // activation routing toward dma and data transfer controllers
      dma_hide = pia_dma_claim(st_r.dma_master_enable, st_r.de, st_r.dsel, '1);
      st_nxt.dma_trig  = src_vec & dma_hide;
      st_nxt.xfer_trig = src_vec & ~dma_hide & st_r.xen;

      // transfer end: clear activation enable and source flag
      flag_clr = pia_dma_claim(st_r.dma_master_enable, st_r.de, st_r.dsel, dma_done_i);
      if (xfer_done_i && (st_r.xsel[xfer_src_i] || xfer_count_zero_i)) begin
         flag_clr[xfer_src_i] = 1'b1;
      end

      // exception start releases an accepted edge request
      acc_is_edge = (st_r.acc_src < SRC_W'(NUM_PINS)) &&
                    st_r.sense[st_r.acc_src[2:0]];
      if (cpu_exc_start_i && st_r.irq && acc_is_edge) begin
         kill[st_r.acc_src] = 1'b1;
      end
      kill = kill | flag_clr;

      // apb access: read data is taken on the edge where pready rises, a write lands on the next edge
      wr = psel_i && penable_i && st_r.pready && pwrite_i;
      rd = psel_i && penable_i && !st_r.pready && !pwrite_i;

      if (wr) begin
         unique case (paddr_i)
            OFS_PRIO_LO:  st_nxt.prio[31:0]  = pwdata_i;
            OFS_PRIO_HI:  st_nxt.prio[63:32] = pwdata_i;
            OFS_SENSE:    st_nxt.sense       = pwdata_i[NUM_PINS-1:0];
            OFS_FLAGS: begin
               for (int i = 0; i < NUM_PINS; i++) begin
                  if (!pwdata_i[i] && st_r.seen_one[i]) begin
                     kill[i]               = 1'b1;
                     st_nxt.seen_one[i]    = 1'b0;
                  end
               end
            end
            OFS_DMA_CTRL: begin
               st_nxt.dma_master_enable = pwdata_i[DMA_CTRL_DME_BIT];
               st_nxt.de  = pwdata_i[DMA_CTRL_DE_LSB +: NUM_DMA_CH];
            end
            OFS_DMA_SEL:  st_nxt.dsel = pwdata_i[NUM_DMA_CH*SRC_W-1:0];
            OFS_XFER_EN:  st_nxt.xen  = pwdata_i[NUM_SRC-1:0];
            OFS_XFER_SEL: st_nxt.xsel = pwdata_i[NUM_SRC-1:0];
            default: ;
         endcase
      end

      // hardware clears the activation enable after a software write
      if (xfer_done_i && (st_r.xsel[xfer_src_i] || xfer_count_zero_i)) begin
         st_nxt.xen[xfer_src_i] = 1'b0;
      end

      // edge flags: clear sources, then a new edge wins over any clear
      for (int i = 0; i < NUM_PINS; i++) begin
         if (kill[i]) begin
            st_nxt.edge_flag[i] = 1'b0;
         end
         if (st_r.sense[i] && pin_fall[i]) begin
            st_nxt.edge_flag[i] = 1'b1;
         end
         if (!st_r.sense[i]) begin
            st_nxt.edge_flag[i] = 1'b0;
         end
      end
      st_nxt.periph_clr = flag_clr[NUM_SRC-1:NUM_PINS];

      // pin judgment state, one extra register for pins only
      st_nxt.pin_stage = pin_flags & ~kill[NUM_PINS-1:0];

      // cpu-bound requests, first compare state
      st_nxt.req = src_vec & ~dma_hide & ~st_r.xen & ~kill;

      // arbitration: descending scan with >= lets the lower index win ties
      for (int s = NUM_SRC - 1; s >= 0; s--) begin
         if (st_r.req[s] && !kill[s] &&
             (!found || pia_level(st_r.prio, s) >= best_lvl)) begin
            found    = 1'b1;
            best_src = SRC_W'(s);
            best_lvl = pia_level(st_r.prio, s);
         end
      end
      st_nxt.win_vld = found;
      st_nxt.win_src = best_src;
      st_nxt.win_lvl = best_lvl;

      // mask compare: strictly above; a raised mask drops the request
      st_nxt.irq = st_r.win_vld && !kill[st_r.win_src] &&
                   (st_r.win_lvl > cpu_mask_level_i);
      st_nxt.irq_n = !st_nxt.irq;
      if (st_nxt.irq) begin
         st_nxt.acc_lvl = st_r.win_lvl;
         st_nxt.acc_src = st_r.win_src;
      end

      // apb read mux and answer
      unique case (paddr_i)
         OFS_PRIO_LO:  rdata = st_r.prio[31:0];
         OFS_PRIO_HI:  rdata = st_r.prio[63:32];
         OFS_SENSE:    rdata = {24'h0, st_r.sense};
         OFS_FLAGS:    rdata = {24'h0, pin_flags};
         OFS_DMA_CTRL: rdata = {27'h0, st_r.de, st_r.dma_master_enable};
         OFS_DMA_SEL:  rdata = {16'h0, st_r.dsel};
         OFS_XFER_EN:  rdata = {16'h0, st_r.xen};
         OFS_XFER_SEL: rdata = {16'h0, st_r.xsel};
         OFS_STATUS: begin
            rdata[STAT_IRQ_BIT]                = st_r.irq;
            rdata[STAT_LVL_LSB +: LVL_W]       = st_r.acc_lvl;
            rdata[STAT_SRC_LSB +: SRC_W]       = st_r.acc_src;
            rdata[STAT_REQ_LSB +: NUM_SRC]     = src_vec;
         end
         default:      bad = 1'b1;
      endcase

      // withdrawal is armed only by a read that saw the flag at one
      if (rd && paddr_i == OFS_FLAGS) begin
         st_nxt.seen_one = st_nxt.seen_one | (pin_flags & st_r.sense);
      end

      // one wait state: pready rises in the second access cycle
      st_nxt.pready  = psel_i && penable_i && !st_r.pready;
      st_nxt.pslverr = st_nxt.pready && bad;
      st_nxt.prdata  = (st_nxt.pready && !pwrite_i && !bad) ? rdata : RST_WORD;
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i || manual_reset_i) begin
         st_r       <= '0;
         st_r.prio  <= RST_PRIO;
         st_r.sense <= RST_SENSE;
         st_r.xen   <= RST_XFER;
         st_r.xsel  <= RST_XFER;
         st_r.dsel  <= RST_DSEL;
         st_r.irq_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign prdata_o          = st_r.prdata;
   assign pready_o          = st_r.pready;
   assign pslverr_o         = st_r.pslverr;
   assign cpu_irq_o         = st_r.irq;
   assign cpu_irq_level_o   = st_r.acc_lvl;
   assign cpu_irq_src_o     = st_r.acc_src;
   assign dma_trigger_o     = st_r.dma_trig;
   assign xfer_trigger_o    = st_r.xfer_trig;
   assign periph_flag_clr_o = st_r.periph_clr;
   // own flop, loaded with the inverse of the request, so pin and cpu line switch together
   assign interrupt_out_n_o = st_r.irq_n;

endmodule

// [bench/pia_top_properties.sv]
// concurrent checks on the ports of the interrupt acceptance block
`timescale 1ns/1ps
module pia_top_properties
   import pia_pkg::*;
(
   input wire logic                  clk_i,
   input wire logic                  reset_i,
   input wire logic                  manual_reset_i,
   input wire logic                  psel_i,
   input wire logic                  penable_i,
   input wire logic                  pready_o,
   input wire logic                  pslverr_o,
   input wire logic [NUM_PERIPH-1:0] periph_req_i,
   input wire logic [NUM_PERIPH-1:0] periph_flag_clr_o,
   input wire logic [LVL_W-1:0]      cpu_mask_level_i,
   input wire logic                  cpu_irq_o,
   input wire logic [LVL_W-1:0]      cpu_irq_level_o,
   input wire logic [SRC_W-1:0]      cpu_irq_src_o,
   input wire logic                  interrupt_out_n_o,
   input wire logic [NUM_SRC-1:0]    dma_trigger_o,
   input wire logic [NUM_DMA_CH-1:0] dma_done_i,
   input wire logic [NUM_SRC-1:0]    xfer_trigger_o,
   input wire logic                  xfer_done_i
);
   // ------------------------------------------------------------------
   // request history, so a rising cpu request can be traced to its cause
   // ------------------------------------------------------------------
   logic [NUM_PERIPH-1:0] req_d1_r, req_d2_r, req_d3_r;
   always_ff @(posedge clk_i) begin
      req_d1_r <= reset_i ? '0 : periph_req_i;
      req_d2_r <= reset_i ? '0 : req_d1_r;
      req_d3_r <= reset_i ? '0 : req_d2_r;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   a_pin_mirror: assert property (interrupt_out_n_o == !cpu_irq_o)
      else $error("request pin differs from cpu request");
   a_mask_strict: assert property ($rose(cpu_irq_o) |->
      cpu_irq_level_o > $past(cpu_mask_level_i))
      else $error("request raised without level above mask");
   a_mask_release: assert property (cpu_irq_o && cpu_mask_level_i >= cpu_irq_level_o |->
      ##[1:2] (!cpu_irq_o || cpu_irq_level_o > cpu_mask_level_i))
      else $error("request held after mask raised");
   a_periph_latency: assert property ($rose(cpu_irq_o) && cpu_irq_src_o[3] |->
      req_d3_r[cpu_irq_src_o[2:0]])
      else $error("peripheral request accepted too early");
   a_dma_hidden: assert property (cpu_irq_o |-> !dma_trigger_o[cpu_irq_src_o])
      else $error("dma claimed source reached cpu");
   a_xfer_hidden: assert property (cpu_irq_o |-> !xfer_trigger_o[cpu_irq_src_o])
      else $error("transfer enabled source reached cpu");
   a_clear_cause: assert property (periph_flag_clr_o != '0 |->
      $past(dma_done_i) != '0 || $past(xfer_done_i))
      else $error("flag cleared without transfer end");
   a_manual_clear: assert property (manual_reset_i |=>
      !cpu_irq_o && dma_trigger_o == '0 && xfer_trigger_o == '0)
      else $error("manual reset left requests alive");
   a_ready_wait: assert property (psel_i && $rose(penable_i) |-> !pready_o ##1 pready_o)
      else $error("apb answer not after one wait");
   a_error_ready: assert property (pslverr_o |-> pready_o)
      else $error("slave error outside ready");
   c_accept: cover property ($rose(cpu_irq_o));
   c_unmapped: cover property (pslverr_o);
   c_flag_clear: cover property (periph_flag_clr_o != '0);
endmodule
bind pia_top pia_top_properties u_props (.clk_i(clk_i), .reset_i(reset_i),
   .manual_reset_i(manual_reset_i), .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .periph_req_i(periph_req_i), .periph_flag_clr_o(periph_flag_clr_o),
   .cpu_mask_level_i(cpu_mask_level_i), .cpu_irq_o(cpu_irq_o), .cpu_irq_level_o(cpu_irq_level_o),
   .cpu_irq_src_o(cpu_irq_src_o), .interrupt_out_n_o(interrupt_out_n_o),
   .dma_trigger_o(dma_trigger_o), .dma_done_i(dma_done_i), .xfer_trigger_o(xfer_trigger_o),
   .xfer_done_i(xfer_done_i));

// [bench/pia_cpu_model.sv]
// behavioural cpu core that takes interrupt requests and raises its mask
`timescale 1ns/1ps
module pia_cpu_model
   import pia_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   input  wire logic             irq_i,
   input  wire logic [LVL_W-1:0] irq_level_i,
   input  wire logic [3:0]       entry_dly_i,
   input  wire logic [3:0]       load_dly_i,
   input  wire logic             mask_we_i,
   input  wire logic [LVL_W-1:0] mask_val_i,
   output logic                  exc_start_o,
   output logic      [LVL_W-1:0] mask_o
);
   // ------------------------------------------------------------------
   // entry sequence; mask_we stands in for the handler's return
   // ------------------------------------------------------------------
   logic [1:0]       st_r;
   logic [3:0]       cnt_r;
   logic [LVL_W-1:0] lvl_r;
   always @(posedge clk_i) begin
      exc_start_o <= !reset_i && !mask_we_i && cnt_r == 4'h0 && st_r == 2'h1;
      if (reset_i) begin
         st_r   <= 2'h0;
         cnt_r  <= 4'h0;
         mask_o <= '0;
      end else if (mask_we_i) begin
         mask_o <= mask_val_i;
      end else if (cnt_r != 4'h0) begin
         cnt_r <= cnt_r - 4'h1;
      end else begin
         case (st_r)
            2'h0: if (irq_i) begin
               st_r  <= 2'h1;
               cnt_r <= entry_dly_i;
            end
            2'h1: begin
               lvl_r       <= irq_level_i;
               st_r        <= 2'h2;
               cnt_r       <= load_dly_i;
            end
            2'h2: begin
               mask_o <= lvl_r;
               st_r   <= 2'h3;
               cnt_r  <= 4'h3;
            end
            default: st_r <= 2'h0;
         endcase
      end
   end
endmodule

// [bench/priority_interrupt_acceptance_test.sv]
// self-checking bench for the interrupt acceptance block
`timescale 1ns/1ps
module priority_interrupt_acceptance_test;
   import pia_pkg::*;
   logic                  clk_i, reset_i, mrst, psel, pen, pwr, pready, perr, irq, irq_n, exc;
   logic                  mset, xdone, xzero, prev_irq;
   logic [ADDR_W-1:0]     paddr;
   logic [31:0]           pwdata, prdata, v;
   logic [NUM_PINS-1:0]   pin_n;
   logic [NUM_PERIPH-1:0] preq, pclr;
   logic [LVL_W-1:0]      mask, ilvl, mval, ldly;
   logic [SRC_W-1:0]      isrc, xsrc;
   logic [NUM_SRC-1:0]    dtrig, xtrig;
   logic [NUM_DMA_CH-1:0] ddone;
   logic [32:0]           rdq[$];
   logic [7:0]            irqq[$];
   int                    fails, comparisons, seed;
   always #50 clk_i = ~clk_i;
   pia_top dut_u (.clk_i(clk_i), .reset_i(reset_i), .manual_reset_i(mrst), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(perr), .pin_req_n_i(pin_n), .periph_req_i(preq),
      .periph_flag_clr_o(pclr), .cpu_mask_level_i(mask), .cpu_exc_start_i(exc),
      .cpu_irq_o(irq), .cpu_irq_level_o(ilvl), .cpu_irq_src_o(isrc),
      .interrupt_out_n_o(irq_n), .dma_trigger_o(dtrig), .dma_done_i(ddone),
      .xfer_trigger_o(xtrig), .xfer_done_i(xdone), .xfer_src_i(xsrc),
      .xfer_count_zero_i(xzero));
   pia_cpu_model u_cpu (.clk_i(clk_i), .reset_i(reset_i), .irq_i(irq), .irq_level_i(ilvl),
      .entry_dly_i(4'h2), .load_dly_i(ldly), .mask_we_i(mset), .mask_val_i(mval),
      .exc_start_o(exc), .mask_o(mask));
   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task automatic check(input logic [35:0] seen, input logic [35:0] exp, input string msg);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t %s seen %h want %h", $time, msg, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk_i);
      pen <= 1'b1;
      @(posedge clk_i);
      while (pready !== 1'b1) @(posedge clk_i);
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      rdq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wait_irq(input logic lv);
      for (int i = 0; i < 60 && irq !== lv; i++) @(posedge clk_i);
   endtask
   task automatic set_mask(input logic [3:0] m);
      @(posedge clk_i);
      mset <= 1'b1;
      mval <= m;
      @(posedge clk_i);
      mset <= 1'b0;
   endtask
   task automatic xfer_end(input logic z, input logic [7:0] e);
      xzero <= z;
      xdone <= 1'b1;
      @(posedge clk_i);
      xdone <= 1'b0;
      @(posedge clk_i);
      check(pclr, e, "transfer end flag clear");
   endtask
   task automatic print_verdict();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // result watcher: oldest note against each answer that appears
   always @(posedge clk_i) begin
      prev_irq <= irq;
      if (pready === 1'b1 && pwr === 1'b0) begin
         if (rdq.size() == 0) check(1'b1, 1'b0, "read without note");
         else check({perr, prdata}, rdq.pop_front(), "read data");
      end
      if (irq === 1'b1 && prev_irq !== 1'b1) begin
         if (irqq.size() == 0) check(1'b1, 1'b0, "unexpected cpu request");
         else check({irq_n, ilvl, isrc}, {1'b0, irqq.pop_front()}, "accepted");
      end
   end
   initial begin
      repeat (6000) @(posedge clk_i);
      fails++;
      print_verdict();
   end
   initial begin
      {clk_i, mrst, psel, pen, pwr, mset, xdone, xzero, prev_irq} = '0;
      {paddr, pwdata, preq, mval, ddone, xsrc, fails, comparisons} = '0;
      reset_i = 1'b1;
      pin_n = 8'hff;
      ldly = 4'h2;
      seed = 18388;
      ticks(10);
      reset_i <= 1'b0;
      rd(OFS_PRIO_LO, 33'h0);
      rd(OFS_STATUS, 33'h0);
      rd(8'h24, {1'b1, 32'h0});
      v = $random(seed);
      apb(1'b1, OFS_PRIO_LO, v);
      rd(OFS_PRIO_LO, {1'b0, v});
      // peripherals: 9 and 10 tie at 7, lower index first
      apb(1'b1, OFS_PRIO_HI, 32'h0000_0775);
      irqq.push_back({4'h7, 4'h9});
      preq <= 8'h07;
      wait_irq(1'b1);
      wait_irq(1'b0);
      check(irq, 1'b0, "release after mask load");
      preq <= 8'h05;
      ticks(6);
      irqq.push_back({4'h7, 4'ha});
      set_mask(4'h0);
      wait_irq(1'b1);
      wait_irq(1'b0);
      preq <= 8'h00;
      set_mask(4'h0);
      // edge pin released at entry, before the mask is loaded
      ldly <= 4'h8;
      apb(1'b1, OFS_PRIO_LO, 32'h0000_0009);
      apb(1'b1, OFS_SENSE, 32'h0000_0001);
      irqq.push_back({4'h9, 4'h0});
      pin_n <= 8'hfe;
      wait_irq(1'b1);
      check(irq, 1'b1, "edge pin request");
      wait_irq(1'b0);
      check({irq, irq_n, mask}, 6'h10, "edge release");
      ticks(12);
      pin_n <= 8'hff;
      ldly <= 4'h2;
      // pending flags under a full mask
      set_mask(4'hf);
      apb(1'b1, OFS_SENSE, 32'h0000_0003);
      pin_n <= 8'hf9;
      ticks(6);
      rd(OFS_FLAGS, {1'b0, 32'h6});
      apb(1'b1, OFS_FLAGS, 32'h0);
      rd(OFS_FLAGS, {1'b0, 32'h4});
      pin_n <= 8'hff;
      ticks(6);
      rd(OFS_FLAGS, 33'h0);
      apb(1'b1, OFS_SENSE, 32'h0000_0008);
      pin_n <= 8'hf7;
      ticks(6);
      rd(OFS_FLAGS, {1'b0, 32'h8});
      mrst <= 1'b1;
      pin_n <= 8'hff;
      ticks(2);
      mrst <= 1'b0;
      ticks(4);
      rd(OFS_FLAGS, 33'h0);
      rd(OFS_SENSE, 33'h0);
      // dma channel 0 claims source 11
      set_mask(4'h0);
      apb(1'b1, OFS_PRIO_HI, 32'h0000_f000);
      apb(1'b1, OFS_DMA_SEL, 32'h0000_000b);
      apb(1'b1, OFS_DMA_CTRL, 32'h0000_0003);
      preq <= 8'h08;
      ticks(5);
      check(dtrig, 16'h0800, "dma trigger");
      ddone <= 4'h1;
      ticks(1);
      ddone <= 4'h0;
      @(posedge clk_i);
      check(pclr, 8'h08, "dma end flag clear");
      preq <= 8'h00;
      apb(1'b1, OFS_DMA_CTRL, 32'h0);
      // transfer controller on source 12
      apb(1'b1, OFS_PRIO_HI, 32'h000f_0000);
      apb(1'b1, OFS_XFER_EN, 32'h0000_1000);
      preq <= 8'h10;
      ticks(5);
      check(xtrig, 16'h1000, "transfer trigger");
      xsrc <= 4'hc;
      xfer_end(1'b0, 8'h00);
      rd(OFS_XFER_EN, {1'b0, 32'h1000});
      set_mask(4'hf);
      xfer_end(1'b1, 8'h10);
      preq <= 8'h00;
      rd(OFS_XFER_EN, 33'h0);
      ticks(4);
      check(irqq.size(), 0, "notes left over");
      print_verdict();
   end
endmodule
